// ### rtl/dpctl_pkg.sv
// Purpose: Shared constants and carrier types for the dual-port RAM host.
// Assumes: One 50 MHz clock; all times are rounded to whole clock cycles.
// Notes:   Least times round up, so every pin interval meets its minimum.
package dpctl_pkg;

   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned ADDR_W        = 11;
   localparam int unsigned DATA_W        = 16;

   // Maximum arbitration time of the arbitrating device.
   localparam int unsigned T_ARB_NS      = 45;
   // Hold of the write pulse past the flag release (write_hold_after_flag).
   localparam int unsigned T_WHOLD_NS    = 30;
   // Least write pulse width; a plain default.
   localparam int unsigned T_WPULSE_NS   = 40;
   // Read access time from select and gate; a plain default.
   localparam int unsigned T_ACCESS_NS   = 100;
   // Flag release to valid read data.
   localparam int unsigned T_FLAG_DATA_NS = 40;

   localparam int unsigned ARB_CYC   = (T_ARB_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int unsigned WHOLD_CYC = (T_WHOLD_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int unsigned WP_CYC    = (T_WPULSE_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int unsigned ACC_CYC   = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int unsigned FDAT_CYC  = (T_FLAG_DATA_NS + CLK_PERIOD_NS - 1)
                                       / CLK_PERIOD_NS;
   localparam int unsigned PULSE_CYC = (WP_CYC > WHOLD_CYC) ? WP_CYC
                                                            : WHOLD_CYC;

   localparam int unsigned CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [1:0]        byte_en;
   } dpctl_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic              contended;
   } dpctl_rsp_t;

   typedef enum logic [2:0] {
      S_IDLE, S_ADDR, S_ARB, S_WRITE, S_READ, S_END
   } dpctl_state_t;

endpackage

// ### rtl/dpctl_port_host.sv
// Purpose: Host controller driving one port of a dual-port static RAM.
// Assumes: Pins are asynchronous to i_ref_clk; data and flag are synced.
// Notes:   Writes run with the output gate high, so no bus turn-around is
//          ever needed inside a write pulse.
//
// Functional notes
// RQ1: Device stores data only while select and byte write strobe overlap low.
// RQ2: Host keeps select or write strobe high whenever address lines change.
// RQ3: Device floats outputs when select falls with or after write strobe.
// RQ4: With output gate low, host stretches write pulse for driver turn-off.
// RQ5: Host never drives data while the port may still drive read data.
// RQ6: Same-location access lets one proceed, flags only the other port.
// RQ7: A write from a flagged port is blocked inside the device.
// RQ8: Arbiter grants the port whose address and select settled first.
// RQ9: Too-close requests still flag exactly one port, which one unknown.
// RQ10: Arbitrating variant drives flags open-drain, pulling only low.
// RQ11: Non-arbitrating variant uses its flag pin purely as write inhibit.
// RQ12: Wide arrays use one arbiter; all others take its flags as inhibit.
// RQ13: Host writes only after flag settles, holds pulse past flag release.
// RQ14: Host delays write pulse by the arbiter's maximum arbitration time.
// RQ15: Select high disables the port, floats both bytes, enters standby.
// RQ16: Select and both strobes low write both bytes whatever the gate.
// RQ17: One strobe low writes that byte; other byte reads or floats.
// RQ18: Select low, strobes high: gate low drives word, gate high floats.
// RQ19: Read data under a low flag may be stale until release plus delay.
// RQ20: Flag goes low on the later port; never both flags low together.
// RQ21: Writes are ignored while the arbiter holds that port's flag low.
// RQ22: Contention needs both ports selected with equal 11-bit addresses.
`timescale 1ns/10ps
`default_nettype none
module dpctl_port_host
   import dpctl_pkg::*;
(
   // Clock and reset
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_b,
   // User request and answer
   input  wire logic              i_req_valid,
   input  wire dpctl_req_t        i_req,
   output logic                   o_req_ready,
   output logic                   o_done,
   output dpctl_rsp_t             o_rsp,
   // RAM port pins
   output logic                   o_sel_n,
   output logic                   o_out_gate_n,
   output logic                   o_low_byte_write_n,
   output logic                   o_high_byte_write_n,
   output logic [ADDR_W-1:0]      o_addr,
   output logic [DATA_W-1:0]      o_data,
   output logic                   o_data_oe,
   input  wire logic [DATA_W-1:0] i_data,
   input  wire logic              i_contention_flag_n
);

   dpctl_state_t      state_r;
   dpctl_state_t      state_nxt;
   logic [CNT_W-1:0]  cnt_r;
   logic              is_write_r;
   logic [1:0]        byte_en_r;
   logic              flag_m_r;
   logic              flag_s_r;
   logic [DATA_W-1:0] din_m_r;
   logic [DATA_W-1:0] din_s_r;

   wire cnt_done   = (cnt_r == CNT_ZERO);
   wire flag_free  = flag_s_r;
   // A request is taken only while ready shows, never in the first edge
   // after reset where ready is still low.
   wire take_req   = (state_r == S_IDLE) && o_req_ready && i_req_valid;
   wire start_wr   = (state_r == S_ARB) && cnt_done && flag_free
                     && is_write_r;
   wire start_rd   = (state_r == S_ARB) && cnt_done && !is_write_r;
   wire wr_abort   = (state_r == S_WRITE) && !flag_free;
   wire wr_finish  = (state_r == S_WRITE) && flag_free && cnt_done;
   wire rd_finish  = (state_r == S_READ) && flag_free && cnt_done;
   wire strobe_act = !o_low_byte_write_n || !o_high_byte_write_n;

   // Both pin inputs pass two flip-flops before any logic looks at them.
   always_ff @(posedge i_ref_clk) begin
      flag_m_r <= i_contention_flag_n;
      flag_s_r <= flag_m_r;
      din_m_r  <= i_data;
      din_s_r  <= din_m_r;
   end

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         S_IDLE:  if (take_req) state_nxt = S_ADDR;
         S_ADDR:  state_nxt = S_ARB;
         S_ARB: begin
            if (start_wr) state_nxt = S_WRITE;
            else if (start_rd) state_nxt = S_READ;
         end
         S_WRITE: begin
            if (wr_abort) state_nxt = S_ARB;
            else if (wr_finish) state_nxt = S_END;
         end
         S_READ:  if (rd_finish) state_nxt = S_END;
         S_END:   state_nxt = S_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         state_r <= S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Wait counter: arbitration delay, pulse width and read access.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         cnt_r <= CNT_ZERO;
      end else if (state_r == S_ADDR) begin
         cnt_r <= CNT_W'(ARB_CYC - 1);                      // RQ14
      end else if (start_wr || (state_r == S_WRITE && !flag_free)) begin
         cnt_r <= CNT_W'(PULSE_CYC - 1);                    // RQ13
      end else if (start_rd) begin
         cnt_r <= CNT_W'(ACC_CYC - 1);
      end else if (state_r == S_READ && !flag_free) begin
         // Stale data under a low flag: restart the wait after release.
         cnt_r <= CNT_W'(FDAT_CYC);
      end else if (!cnt_done) begin
         cnt_r <= cnt_r - 4'h1;
      end
   end

   // Request capture; the address only moves while select is high.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_addr     <= '0;
         o_data     <= '0;
         is_write_r <= 1'b0;
         byte_en_r  <= 2'h0;
      end else if (take_req) begin
         o_addr     <= i_req.addr;                           // RQ2
         o_data     <= i_req.wdata;
         is_write_r <= i_req.write;
         byte_en_r  <= i_req.byte_en;
      end
   end

   // Select stays low from address phase to the end of the access.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_sel_n <= 1'b1;
      end else if (state_r == S_ADDR) begin
         o_sel_n <= 1'b0;
      end else if (state_r == S_END) begin
         o_sel_n <= 1'b1;
      end
   end

   // The gate opens only for reads, never while write data is driven.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_out_gate_n <= 1'b1;
      end else if (start_rd) begin
         o_out_gate_n <= 1'b0;
      end else if (rd_finish) begin
         o_out_gate_n <= 1'b1;                               // RQ4
      end
   end

   // Strobes fall only with a released synced flag and drop at the first edge
   // where the synced flag shows low, so a blocked pulse is retried in full.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_low_byte_write_n  <= 1'b1;
         o_high_byte_write_n <= 1'b1;
      end else if (start_wr) begin
         o_low_byte_write_n  <= !byte_en_r[0];              // RQ13
         o_high_byte_write_n <= !byte_en_r[1];              // RQ13
      end else if (wr_abort || wr_finish) begin
         o_low_byte_write_n  <= 1'b1;
         o_high_byte_write_n <= 1'b1;
      end
   end

   // Data is driven one cycle after the gate has been high, and is held
   // through the end cycle to cover the data hold after the strobe.
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_data_oe <= 1'b0;
      end else if (start_wr) begin
         o_data_oe <= 1'b1;                                  // RQ5
      end else if (state_r == S_END) begin
         o_data_oe <= 1'b0;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_rsp       <= '0;
         o_done      <= 1'b0;
         o_req_ready <= 1'b0;
      end else begin
         o_done      <= (state_r == S_END);
         o_req_ready <= (state_nxt == S_IDLE);
         if (take_req) begin
            o_rsp.contended <= 1'b0;
         end else if (!flag_free && state_r != S_IDLE
                      && state_r != S_END) begin
            o_rsp.contended <= 1'b1;
         end
         if (rd_finish) begin
            o_rsp.rdata <= din_s_r;
         end
      end
   end

   // Helper: cycles that select has been low before the strobe falls.
   logic [CNT_W-1:0] sel_low_cnt_r;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b || o_sel_n) begin
         sel_low_cnt_r <= CNT_ZERO;
      end else if (sel_low_cnt_r != 4'hF) begin
         sel_low_cnt_r <= sel_low_cnt_r + 4'h1;
      end
   end

   localparam int ARB_MIN = ARB_CYC;

   AST_ADDR_STABLE: assert property ( // RQ2
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (!o_sel_n && $past(!o_sel_n)) |-> $stable(o_addr))
      else $error("Address moved while the port was selected.");

   AST_NO_CLASH: assert property ( // RQ5
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_data_oe |-> (o_out_gate_n && $past(o_out_gate_n)))
      else $error("Data driven while the port could drive read data.");

   AST_GATE_HIGH_IN_WRITE: assert property ( // RQ4
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      strobe_act |-> (o_out_gate_n && o_data_oe))
      else $error("Write pulse with the gate low or data not driven.");

   AST_ARB_DELAY: assert property ( // RQ14
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(strobe_act) |-> (sel_low_cnt_r >= ARB_MIN))
      else $error("Write pulse came before the arbitration time.");

   AST_FLAG_SETTLED: assert property ( // RQ13
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(strobe_act) |-> $past(flag_s_r))
      else $error("Write started under a low contention flag.");

   AST_PULSE_HOLD: assert property ( // RQ13
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      ($rose(strobe_act) && flag_s_r)
         |=> (strobe_act || !$past(flag_s_r)))
      else $error("Write pulse shorter than the hold past the flag.");

   AST_ABORT_ON_FLAG: assert property ( // RQ12
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      (strobe_act && !flag_s_r) |=> !strobe_act)
      else $error("Write pulse kept during a contention flag.");

   AST_DONE_DESELECT: assert property ( // RQ2
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      o_done |-> (o_sel_n && !strobe_act && !o_data_oe))
      else $error("Access reported done with the port still active.");

   COV_WRITE: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      $rose(strobe_act) ##[1:8] o_done);
   COV_READ: cover property (@(posedge i_ref_clk) disable iff (!i_rst_b)
      $fell(o_out_gate_n) ##[1:20] o_done);
   COV_WRITE_BLOCKED: cover property (@(posedge i_ref_clk)
      disable iff (!i_rst_b)
      (strobe_act && !flag_s_r) ##1 !strobe_act ##[1:20] strobe_act);

endmodule // dpctl_port_host
`default_nettype wire

// ### verification/dpctl_ram_model.sv
// Purpose: Behavioural model of one port of the dual-port RAM.
// Assumes: The opposite port is reduced to a select and an address.
// Notes:   The opposite port always settled first, so this port loses.
`timescale 1ns/10ps
`default_nettype none
module dpctl_ram_model
   import dpctl_pkg::*;
(
   // Clock for the float pattern and pin checks
   input  wire logic              i_ref_clk,
   // Port pins
   input  wire logic              i_sel_n,
   input  wire logic              i_out_gate_n,
   input  wire logic              i_low_byte_write_n,
   input  wire logic              i_high_byte_write_n,
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [DATA_W-1:0] i_hd,
   input  wire logic              i_hoe,
   // Opposite port
   input  wire logic              i_oth_sel,
   input  wire logic [ADDR_W-1:0] i_oth_addr,
   // Resolved wires and pin fault flag
   output wire logic [DATA_W-1:0] o_pin,
   output wire logic              o_flag_n,
   output wire logic              o_viol
);
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [ADDR_W-1:0] addr_q;
   logic              tgl_r = 1'b0;
   logic              viol_r = 1'b0;
   wire hit_w = ~i_sel_n & i_oth_sel & (i_addr == i_oth_addr);
   // Open drain: released means the pull-up level.
   assign o_flag_n = ~hit_w;
   wire [1:0] stb_w = ~{i_high_byte_write_n, i_low_byte_write_n};
   wire [1:0] wr_w  = stb_w & {2{~i_sel_n & o_flag_n}};
   wire [1:0] rd_w  = ~stb_w & {2{~i_sel_n & ~i_out_gate_n}};
   // A floating byte changes every cycle so no stale value looks valid.
   wire [7:0] junk_w = tgl_r ? 8'hA5 : 8'h5A;
   wire [7:0] lo_w   = o_flag_n ? mem[i_addr][7:0] : junk_w;
   wire [7:0] hi_w   = o_flag_n ? mem[i_addr][15:8] : junk_w;
   assign o_pin[7:0]  = rd_w[0] ? lo_w : (i_hoe ? i_hd[7:0] : junk_w);
   assign o_pin[15:8] = rd_w[1] ? hi_w : (i_hoe ? i_hd[15:8] : junk_w);
   assign o_viol = viol_r;
   always @* begin
      if (wr_w[0]) mem[i_addr][7:0] = o_pin[7:0];
      if (wr_w[1]) mem[i_addr][15:8] = o_pin[15:8];
   end
   always_ff @(posedge i_ref_clk) begin
      tgl_r  <= ~tgl_r;
      addr_q <= i_addr;
      if ((|rd_w & i_hoe) | ((i_addr != addr_q) & ~i_sel_n & |stb_w))
         viol_r <= 1'b1;
   end
endmodule // dpctl_ram_model
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench of the dual-port RAM port host.
// Assumes: 50 MHz clock; the RAM model stands on the port pins.
// Notes:   Outputs are sampled at the falling edge, requests change at rise.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin \
   err_count++; \
   $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module testbench;
   import dpctl_pkg::*;
   logic              clk = 1'b0;
   logic              rst_b = 1'b0;
   logic              req_valid = 1'b0;
   dpctl_req_t        req = '0;
   logic              oth_sel = 1'b0;
   logic [ADDR_W-1:0] oth_addr = '0;
   logic              ready, done, sel_n, gate_n, lbw_n, hbw_n;
   logic              d_oe, flag_n, viol;
   dpctl_rsp_t        rsp;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] hd, pin;
   int                err_count = 0;
   int                checks_done = 0;
   dpctl_port_host dut_u (.i_ref_clk(clk), .i_rst_b(rst_b),
      .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready),
      .o_done(done), .o_rsp(rsp), .o_sel_n(sel_n), .o_out_gate_n(gate_n),
      .o_low_byte_write_n(lbw_n), .o_high_byte_write_n(hbw_n),
      .o_addr(addr), .o_data(hd), .o_data_oe(d_oe), .i_data(pin),
      .i_contention_flag_n(flag_n));
   dpctl_ram_model ram_u (.i_ref_clk(clk), .i_sel_n(sel_n),
      .i_out_gate_n(gate_n), .i_low_byte_write_n(lbw_n),
      .i_high_byte_write_n(hbw_n), .i_addr(addr), .i_hd(hd),
      .i_hoe(d_oe), .i_oth_sel(oth_sel), .i_oth_addr(oth_addr),
      .o_pin(pin), .o_flag_n(flag_n), .o_viol(viol));
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One access; returns at the falling edge where done stands high.
   task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d, input logic [1:0] be);
      int n;
      n = 0;
      @(negedge clk);
      while (ready !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      `CHK("ready", 1'b1, ready)
      @(posedge clk);
      req_valid <= 1'b1;
      req <= '{write: w, addr: a, wdata: d, byte_en: be};
      @(posedge clk);
      req_valid <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 300) begin
         @(negedge clk);
         n++;
      end
      `CHK("done", 1'b1, done)
   endtask
   task automatic t_reset();
      `CHK("sel_n_reset", 1'b1, sel_n)
      `CHK("oe_reset", 1'b0, d_oe)
      $display("test reset ended");
   endtask
   task automatic t_word();
      for (int i = 0; i < 2; i++) begin
         access(1'b1, i ? 11'h7FF : 11'h000, 16'hA55A ^ i, 2'b11);
         access(1'b0, i ? 11'h7FF : 11'h000, 16'h0000, 2'b00);
         `CHK("word", 16'hA55A ^ i, rsp.rdata)
      end
      $display("test word ended");
   endtask
   task automatic t_bytes();
      access(1'b1, 11'h123, 16'h1234, 2'b11);
      access(1'b1, 11'h123, 16'hABCD, 2'b01);
      access(1'b0, 11'h123, 16'h0000, 2'b00);
      `CHK("low_byte", 16'h12CD, rsp.rdata)
      access(1'b1, 11'h123, 16'h9876, 2'b10);
      access(1'b1, 11'h123, 16'hFFFF, 2'b00);
      access(1'b0, 11'h123, 16'h0000, 2'b00);
      `CHK("high_byte", 16'h98CD, rsp.rdata)
      $display("test bytes ended");
   endtask
   task automatic t_busy(input logic w);
      access(1'b1, 11'h055, 16'h1111, 2'b11);
      @(posedge clk);
      oth_addr <= 11'h055;
      oth_sel  <= 1'b1;
      fork
         access(w, 11'h055, 16'h2222, 2'b11);
         begin
            repeat (40) @(negedge clk);
            `CHK("held", 1'b0, done)
            `CHK("blocked", 16'h1111, ram_u.mem[11'h055])
            @(posedge clk);
            oth_sel <= 1'b0;
         end
      join
      `CHK("contended", 1'b1, rsp.contended)
      `CHK("busy_rd", 16'h1111, rsp.rdata)
      access(1'b0, 11'h055, 16'h0000, 2'b00);
      `CHK("after", w ? 16'h2222 : 16'h1111, rsp.rdata)
      $display("test busy ended");
   endtask
   task automatic t_near();
      @(posedge clk);
      oth_addr <= 11'h056;
      oth_sel  <= 1'b1;
      access(1'b1, 11'h055, 16'h3333, 2'b11);
      `CHK("no_hit", 1'b0, rsp.contended)
      access(1'b0, 11'h055, 16'h0000, 2'b00);
      `CHK("near", 16'h3333, rsp.rdata)
      `CHK("pins", 1'b0, viol)
      oth_sel <= 1'b0;
      $display("test near ended");
   endtask
   // The other port arrives one cycle after select falls, two cycles before the
   // strobe, so the strobe falls under a low flag and the pulse must restart.
   task automatic t_abort();
      access(1'b1, 11'h0AA, 16'h0F0F, 2'b11);
      oth_addr <= 11'h0AA;
      fork
         access(1'b1, 11'h0AA, 16'h4444, 2'b11);
         begin
            @(negedge sel_n);
            @(posedge clk);
            oth_sel <= 1'b1;
            repeat (12) @(negedge clk);
            `CHK("abort_blk", 16'h0F0F, ram_u.mem[11'h0AA])
            @(posedge clk);
            oth_sel <= 1'b0;
         end
      join
      `CHK("abort_flag", 1'b1, rsp.contended)
      `CHK("abort_retry", 16'h4444, ram_u.mem[11'h0AA])
      `CHK("pins_abort", 1'b0, viol)
      $display("test abort ended");
   endtask
   initial begin
      repeat (5) @(negedge clk);
      t_reset();
      repeat (5) @(posedge clk);
      rst_b <= 1'b1;
      t_word();
      t_bytes();
      t_busy(1'b0);
      t_busy(1'b1);
      t_near();
      t_abort();
      wrap_up();
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
